/* gpdi_device.sv */
`timescale 1ns/1ps
module gpdi_device (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // bus pins, all low true
  input wire logic [7:0] i_dio_n,
  output logic [7:0] o_dio_n,
  output logic o_dio_oe_n,
  input wire logic i_atn_n,
  input wire logic i_ifc_n,
  input wire logic i_ren_n,
  input wire logic i_eoi_n,
  output logic o_eoi_n,
  output logic o_eoi_oe_n,
  input wire logic i_srq_n,
  output logic o_srq_n,
  output logic o_srq_oe_n,
  input wire logic i_dav_n,
  output logic o_dav_n,
  output logic o_dav_oe_n,
  input wire logic i_nrfd_n,
  output logic o_nrfd_n,
  output logic o_nrfd_oe_n,
  input wire logic i_ndac_n,
  output logic o_ndac_n,
  output logic o_ndac_oe_n,
  // instrument side
  input wire logic [4:0] i_pri_addr,
  input wire logic i_srq_req,
  input wire logic [5:0] i_status,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic [7:0] o_rx_data,
  output logic o_rx_last,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_last,
  output logic o_remote,
  output logic o_lockout,
  output logic o_talker,
  output logic o_listener,
  output logic o_poll_mode,
  output logic o_dev_clear,
  output logic o_trigger
);
  typedef enum logic [1:0] {A_IDLE, A_TAKE, A_DONE} gpdi_acc_state_t;

  // ---------------------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------------------
  // address group of a command byte, top two of the seven low bits
  function automatic logic [1:0] grp_of(input logic [6:0] b);
    grp_of = b[6:5];
  endfunction : grp_of

  function automatic logic addr_hit(input logic [6:0] b, input logic [1:0] grp, input logic [4:0] a);
    addr_hit = (grp_of(b) == grp) && (b[4:0] == a);
  endfunction : addr_hit

  // ---------------------------------------------------------------------------
  // bus line levels, turned into true-high
  // ---------------------------------------------------------------------------
  logic atn;
  logic ifc;
  logic ren;
  logic dav;
  assign atn = ~i_atn_n;
  assign ifc = ~i_ifc_n;
  assign ren = ~i_ren_n;
  assign dav = ~i_dav_n;

  gpdi_byte_if rx_in ();
  gpdi_byte_if rx_out ();
  gpdi_byte_if tx_bus ();

  gpdi_acc_state_t acc_state;
  logic [7:0] cap_byte;
  logic cap_last;
  logic cap_cmd;
  logic nrfd_drv;
  logic ndac_drv;
  logic atn_d;
  logic ren_d;
  logic [3:0] atn_guard;
  logic guard_busy;
  logic acc_active;
  logic can_take;
  logic cmd_strobe;
  logic [6:0] cmd;
  logic addressed_cmd;
  logic src_abort;
  logic src_dio_oe_n;
  logic src_eoi_oe_n;
  logic [7:0] src_dio_n;

  // ---------------------------------------------------------------------------
  // atn guard window
  // ---------------------------------------------------------------------------
  // hold the acceptor lines still right after attention is asserted
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      atn_d <= 1'b0;
      atn_guard <= '0;
    end
    else
    begin
      atn_d <= atn;
      if (atn && !atn_d)
        atn_guard <= gpdi_pkg::ATN_STABLE_CNT;
      else if (atn_guard != '0)
        atn_guard <= atn_guard - 1'b1;
    end
  end

  assign guard_busy = (atn && !atn_d) || (atn_guard != '0);

  // ---------------------------------------------------------------------------
  // acceptor handshake
  // ---------------------------------------------------------------------------
  // every device accepts while attention is true, data only when listening
  assign acc_active = atn || (o_listener && !ifc);
  // commands are always taken, data only when the buffer has room
  assign can_take = atn || rx_in.ready;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      acc_state <= A_IDLE;
      nrfd_drv <= 1'b0;
      ndac_drv <= 1'b0;
      cap_byte <= '0;
      cap_last <= 1'b0;
      cap_cmd <= 1'b0;
    end
    else if (!guard_busy)
    begin
      if (!acc_active)
      begin
        // not taking part: both lines released
        acc_state <= A_IDLE;
        nrfd_drv <= 1'b0;
        ndac_drv <= 1'b0;
      end
      else
      begin
        unique case (acc_state)
          A_IDLE:
            begin
              ndac_drv <= 1'b1;
              nrfd_drv <= !can_take;
              if (dav && !nrfd_drv)
              begin
                cap_byte <= ~i_dio_n;
                cap_last <= ~i_eoi_n;
                cap_cmd <= atn;
                nrfd_drv <= 1'b1;
                acc_state <= A_TAKE;
              end
            end
          A_TAKE:
            // a command is consumed at once, data waits for the buffer
            if (cap_cmd || rx_in.ready)
            begin
              ndac_drv <= 1'b0;
              acc_state <= A_DONE;
            end
          A_DONE:
            if (!dav)
            begin
              ndac_drv <= 1'b1;
              acc_state <= A_IDLE;
            end
          default:
            acc_state <= A_IDLE;
        endcase
      end
    end
  end

  // data bytes enter the buffer in the take cycle
  assign rx_in.valid = (acc_state == A_TAKE) && !cap_cmd && !guard_busy && acc_active;
  assign rx_in.data = cap_byte;
  assign rx_in.last = cap_last;

  // a command is acted on exactly once, as the acceptor leaves the take state
  assign cmd_strobe = (acc_state == A_TAKE) && cap_cmd && !guard_busy && acc_active;
  assign cmd = cap_byte[6:0];
  assign addressed_cmd = cmd_strobe && o_listener;

  // ---------------------------------------------------------------------------
  // receive buffer
  // ---------------------------------------------------------------------------
  // two entries let the bus finish a byte while the instrument is stalled
  gpdi_buf2 #(
    .DEPTH(2)
  ) u_rx_buf (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .s_in(rx_in),
    .s_out(rx_out)
  );

  assign o_rx_valid = rx_out.valid;
  assign rx_out.ready = i_rx_ready;
  assign o_rx_data = rx_out.data;
  assign o_rx_last = rx_out.last;

  // ---------------------------------------------------------------------------
  // addressing
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_listener <= 1'b0;
      o_talker <= 1'b0;
    end
    else if (ifc)
    begin
      o_listener <= 1'b0;
      o_talker <= 1'b0;
    end
    else if (cmd_strobe && grp_of(cmd) != gpdi_pkg::GRP_SECONDARY)
    begin
      if (cmd == gpdi_pkg::CMD_UNLISTEN)
        o_listener <= 1'b0;
      else if (addr_hit(cmd, gpdi_pkg::GRP_LISTEN, i_pri_addr))
        o_listener <= 1'b1;
      if (cmd == gpdi_pkg::CMD_UNTALK)
        o_talker <= 1'b0;
      else if (addr_hit(cmd, gpdi_pkg::GRP_TALK, i_pri_addr))
        o_talker <= 1'b1;
      else if (grp_of(cmd) == gpdi_pkg::GRP_TALK)
        o_talker <= 1'b0; // another talker was named, only one may talk
    end
  end

  // ---------------------------------------------------------------------------
  // remote, lockout and serial poll state
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ren_d <= 1'b0;
      o_remote <= 1'b0;
      o_lockout <= 1'b0;
    end
    else
    begin
      ren_d <= ren;
      if (!ren)
      begin
        // without remote enable the front panel always rules
        o_remote <= 1'b0;
        o_lockout <= 1'b0;
      end
      else
      begin
        if (ren && !ren_d)
          o_remote <= 1'b1;
        else if (addressed_cmd && cmd == gpdi_pkg::CMD_GO_LOCAL)
          o_remote <= 1'b0;
        else if (cmd_strobe && addr_hit(cmd, gpdi_pkg::GRP_LISTEN, i_pri_addr))
          o_remote <= 1'b1;
        if (cmd_strobe && cmd == gpdi_pkg::CMD_LOCKOUT)
          o_lockout <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_poll_mode <= 1'b0;
    else if (ifc)
      o_poll_mode <= 1'b0;
    else if (cmd_strobe && cmd == gpdi_pkg::CMD_POLL_ON)
      o_poll_mode <= 1'b1;
    else if (cmd_strobe && cmd == gpdi_pkg::CMD_POLL_OFF)
      o_poll_mode <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // one-cycle requests to the instrument
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_dev_clear <= 1'b0;
      o_trigger <= 1'b0;
    end
    else
    begin
      o_dev_clear <= (cmd_strobe && cmd == gpdi_pkg::CMD_DEV_CLEAR)
        || (addressed_cmd && cmd == gpdi_pkg::CMD_SEL_CLEAR);
      o_trigger <= addressed_cmd && cmd == gpdi_pkg::CMD_TRIGGER;
    end
  end

  // ---------------------------------------------------------------------------
  // talker source
  // ---------------------------------------------------------------------------
  // in poll mode the status byte replaces instrument data
  assign src_abort = atn || ifc || !o_talker;
  assign tx_bus.valid = o_poll_mode ? 1'b1 : i_tx_valid;
  assign tx_bus.data = o_poll_mode ? {1'b0, i_srq_req, i_status} : i_tx_data;
  assign tx_bus.last = o_poll_mode ? 1'b1 : i_tx_last;
  assign o_tx_ready = tx_bus.ready && !o_poll_mode;

  gpdi_source u_source (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_abort(src_abort),
    .i_nrfd_n(i_nrfd_n),
    .i_ndac_n(i_ndac_n),
    .s_tx(tx_bus),
    .o_dio_n(src_dio_n),
    .o_dio_oe_n(src_dio_oe_n),
    .o_dav_oe_n(o_dav_oe_n),
    .o_eoi_oe_n(src_eoi_oe_n)
  );

  assign o_dio_n = src_dio_n;
  assign o_dio_oe_n = src_dio_oe_n;
  assign o_eoi_oe_n = src_eoi_oe_n;

  // ---------------------------------------------------------------------------
  // open-drain pin drive
  // ---------------------------------------------------------------------------
  // these lines are only ever pulled low; a release lets the bus float high
  assign o_eoi_n = 1'b0;
  assign o_dav_n = 1'b0;
  assign o_nrfd_n = 1'b0;
  assign o_ndac_n = 1'b0;
  assign o_srq_n = 1'b0;
  assign o_nrfd_oe_n = ~nrfd_drv;
  assign o_ndac_oe_n = ~ndac_drv;
  assign o_srq_oe_n = ~i_srq_req;
endmodule : gpdi_device

/* gpdi_pkg.sv */
package gpdi_pkg;
  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned T_ATN_STABLE_NS = 100;
  localparam int unsigned T_SETTLE_NS = 50;
  // least times round up to whole cycles
  localparam int unsigned ATN_STABLE_CYC = (T_ATN_STABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SETTLE_CYC = (T_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] ATN_STABLE_CNT = 4'(ATN_STABLE_CYC);
  localparam logic [3:0] SETTLE_CNT = 4'(SETTLE_CYC);
  // ---------------------------------------------------------------------------
  // multiline command codes, dio8 taken as zero
  // ---------------------------------------------------------------------------
  localparam logic [6:0] CMD_GO_LOCAL = 7'h01;
  localparam logic [6:0] CMD_SEL_CLEAR = 7'h04;
  localparam logic [6:0] CMD_TRIGGER = 7'h08;
  localparam logic [6:0] CMD_LOCKOUT = 7'h11;
  localparam logic [6:0] CMD_DEV_CLEAR = 7'h14;
  localparam logic [6:0] CMD_POLL_ON = 7'h18;
  localparam logic [6:0] CMD_POLL_OFF = 7'h19;
  localparam logic [6:0] CMD_UNLISTEN = 7'h3F;
  localparam logic [6:0] CMD_UNTALK = 7'h5F;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [1:0] GRP_SECONDARY = 2'h3;
  // ---------------------------------------------------------------------------
  // serial poll status byte
  // ---------------------------------------------------------------------------
  localparam int unsigned POLL_RQS_BIT = 6;
  localparam int unsigned BYTE_W = 8;
endpackage : gpdi_pkg

/* gpdi_byte_if.sv */
`timescale 1ns/1ps
// byte stream with end marker, valid/ready handshake
interface gpdi_byte_if;
  logic valid;
  logic ready;
  logic [gpdi_pkg::BYTE_W-1:0] data;
  logic last;
  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface : gpdi_byte_if

/* gpdi_buf2.sv */
`timescale 1ns/1ps
module gpdi_buf2 #(
  parameter int unsigned DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  gpdi_byte_if.snk s_in,
  gpdi_byte_if.src s_out
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [gpdi_pkg::BYTE_W:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // ready drops when full so the acceptor holds off the bus
  assign s_in.ready = (count != FULL_CNT);
  assign s_out.valid = (count != '0);
  assign s_out.data = mem[rd_ptr][gpdi_pkg::BYTE_W-1:0];
  assign s_out.last = mem[rd_ptr][gpdi_pkg::BYTE_W];
  assign push = s_in.valid && s_in.ready;
  assign pop = s_out.valid && s_out.ready;

  // storage, no reset needed on the data array
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= {s_in.last, s_in.data};
    end
  end

  // pointers and fill level
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule : gpdi_buf2

/* gpdi_source.sv */
`timescale 1ns/1ps
module gpdi_source (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_abort,
  input wire logic i_nrfd_n,
  input wire logic i_ndac_n,
  gpdi_byte_if.snk s_tx,
  output logic [7:0] o_dio_n,
  output logic o_dio_oe_n,
  output logic o_dav_oe_n,
  output logic o_eoi_oe_n
);
  typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_WAIT_RDY, S_VALID, S_WAIT_NDAC} gpdi_src_state_t;
  gpdi_src_state_t state;
  logic [3:0] settle;

  // a byte is taken from the stream only when the bus side is free
  assign s_tx.ready = (state == S_IDLE) && !i_abort;

  // ---------------------------------------------------------------------------
  // source handshake
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= S_IDLE;
      settle <= '0;
      o_dio_n <= 8'hFF;
      o_dio_oe_n <= 1'b1;
      o_dav_oe_n <= 1'b1;
      o_eoi_oe_n <= 1'b1;
    end
    else if (i_abort)
    begin
      // controller took the bus: let go of every line at once
      state <= S_IDLE;
      o_dio_oe_n <= 1'b1;
      o_dav_oe_n <= 1'b1;
      o_eoi_oe_n <= 1'b1;
    end
    else
    begin
      unique case (state)
        S_IDLE:
          if (s_tx.valid)
          begin
            o_dio_n <= ~s_tx.data;
            o_dio_oe_n <= 1'b0;
            o_eoi_oe_n <= ~s_tx.last;
            settle <= gpdi_pkg::SETTLE_CNT;
            state <= S_SETTLE;
          end
        S_SETTLE:
          begin
            // let the data lines settle before they are offered as valid
            settle <= settle - 1'b1;
            if (settle == 4'h1)
              state <= S_WAIT_RDY;
          end
        S_WAIT_RDY:
          if (i_nrfd_n && !i_ndac_n)
          begin
            o_dav_oe_n <= 1'b0;
            state <= S_VALID;
          end
        S_VALID:
          if (i_ndac_n)
          begin
            o_dav_oe_n <= 1'b1;
            state <= S_WAIT_NDAC;
          end
        S_WAIT_NDAC:
          if (!i_ndac_n)
          begin
            o_dio_oe_n <= 1'b1;
            o_eoi_oe_n <= 1'b1;
            state <= S_IDLE;
          end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule : gpdi_source

/* gpdi_device_assertions.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker for the instrument bus interface
// ------------------------------------------------------------
module gpdi_device_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_dio_n,
  input wire logic i_atn_n,
  input wire logic i_ifc_n,
  input wire logic i_ren_n,
  input wire logic i_dav_n,
  input wire logic i_nrfd_n,
  input wire logic i_ndac_n,
  input wire logic i_srq_req,
  input wire logic o_srq_n,
  input wire logic o_srq_oe_n,
  input wire logic o_dio_oe_n,
  input wire logic o_eoi_oe_n,
  input wire logic o_dav_oe_n,
  input wire logic o_nrfd_oe_n,
  input wire logic o_ndac_oe_n,
  input wire logic o_remote,
  input wire logic o_lockout,
  input wire logic o_talker,
  input wire logic o_listener,
  input wire logic o_poll_mode,
  input wire logic o_dev_clear,
  input wire logic o_trigger
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // named steps, each used by one property
  sequence s_src_done;
    !o_dav_oe_n && i_ndac_n;
  endsequence
  sequence s_ifc_held;
    !i_ifc_n ##1 !i_ifc_n;
  endsequence
  sequence s_ren_idle;
    i_ren_n [*3];
  endsequence
  // source: dav waits for ready acceptors, drops once accepted
  property p_src_wait;
    $fell(o_dav_oe_n) |-> $past(i_nrfd_n) && !$past(i_ndac_n);
  endproperty
  a_src_wait: assert property (p_src_wait) else $error("dav pulled early");
  property p_src_drop;
    s_src_done |-> ##[1:2] o_dav_oe_n;
  endproperty
  a_src_drop: assert property (p_src_drop) else $error("dav held after accept");
  property p_dav_data;
    (!o_dav_oe_n || !o_eoi_oe_n) |-> !o_dio_oe_n;
  endproperty
  a_dav_data: assert property (p_dav_data) else $error("dav or eoi without byte");
  // no sourcing under attention or when not talker
  property p_quiet;
    (!o_talker || !i_atn_n) |-> ##[1:2] (o_dav_oe_n && o_dio_oe_n);
  endproperty
  a_quiet: assert property (p_quiet) else $error("sourcing while not allowed");
  // acceptor: nrfd follows dav, ndac only released mid transfer
  property p_acc_nrfd;
    $fell(o_nrfd_oe_n) |-> !$past(i_dav_n);
  endproperty
  a_acc_nrfd: assert property (p_acc_nrfd) else $error("nrfd pulled without dav");
  property p_acc_close;
    (o_ndac_oe_n && !o_nrfd_oe_n && i_dav_n) |-> ##[1:2] !o_ndac_oe_n;
  endproperty
  a_acc_close: assert property (p_acc_close) else $error("ndac not pulled again");
  property p_srq;
    (o_srq_oe_n == !i_srq_req) && !o_srq_n;
  endproperty
  a_srq: assert property (p_srq) else $error("srq mismatch");
  property p_ifc;
    s_ifc_held |=> !o_talker && !o_listener && !o_poll_mode;
  endproperty
  a_ifc: assert property (p_ifc) else $error("ifc left addressing");
  property p_ren;
    s_ren_idle |-> !o_remote && !o_lockout;
  endproperty
  a_ren: assert property (p_ren) else $error("remote without ren");
  // command pulses tied to the byte seen two cycles earlier
  property p_trig;
    o_trigger |-> $past(o_listener, 2) && !$past(i_atn_n, 2)
      && (((~$past(i_dio_n, 2)) & 8'h7F) == {1'b0, gpdi_pkg::CMD_TRIGGER});
  endproperty
  a_trig: assert property (p_trig) else $error("stray trigger");
  property p_clear;
    o_dev_clear |-> !$past(i_atn_n, 2)
      && ((((~$past(i_dio_n, 2)) & 8'h7F) == {1'b0, gpdi_pkg::CMD_DEV_CLEAR})
      || ((((~$past(i_dio_n, 2)) & 8'h7F) == {1'b0, gpdi_pkg::CMD_SEL_CLEAR}) && $past(o_listener, 2)));
  endproperty
  a_clear: assert property (p_clear) else $error("stray device clear");
endmodule : gpdi_device_chk

bind gpdi_device gpdi_device_chk u_chk (.*);

/* gpdi_ctl_model.sv */
`timescale 1ns/1ps
// bus controller: sources commands and data, accepts talker bytes
module gpdi_ctl_model (
  input wire logic i_clk,
  input wire logic [7:0] i_dio_n,
  input wire logic i_eoi_n,
  input wire logic i_dav_n,
  input wire logic i_ndac_n,
  input wire logic i_nrfd_n,
  output logic [7:0] o_dio_n,
  output logic o_dio_oe_n,
  output logic o_atn_n,
  output logic o_ifc_n,
  output logic o_ren_n,
  output logic o_eoi_oe_n,
  output logic o_dav_oe_n,
  output logic o_nrfd_oe_n,
  output logic o_ndac_oe_n
);
  // everything released at start, high level reads as false
  initial
  begin
    o_dio_n = 8'hFF;
    {o_dio_oe_n, o_atn_n, o_ifc_n, o_ren_n} = 4'hF;
    {o_eoi_oe_n, o_dav_oe_n, o_nrfd_oe_n, o_ndac_oe_n} = 4'hF;
  end
  // only the controller moves ren and ifc
  task ctl(input logic ren, input logic ifc);
    @(posedge i_clk) #2;
    o_ren_n = !ren;
    o_ifc_n = !ifc;
  endtask : ctl
  // one byte as source; acceptors get the attention guard first
  task send(input logic [7:0] b, input logic atn, input logic eoi);
    @(posedge i_clk) #2;
    {o_nrfd_oe_n, o_ndac_oe_n} = 2'h3;
    o_atn_n = !atn;
    o_dio_n = ~b;
    o_dio_oe_n = 1'b0;
    o_eoi_oe_n = !eoi;
    repeat (5) @(posedge i_clk);
    do @(negedge i_clk); while (!(i_nrfd_n && !i_ndac_n));
    @(posedge i_clk) #2 o_dav_oe_n = 1'b0;
    do @(negedge i_clk); while (!i_ndac_n);
    @(posedge i_clk) #2 o_dav_oe_n = 1'b1;
    do @(negedge i_clk); while (i_ndac_n);
    @(posedge i_clk) #2 o_dio_oe_n = 1'b1;
    o_eoi_oe_n = 1'b1;
  endtask : send
  // accept one byte; d extra cycles before ndac lets go, for a slow reader
  task recv(output logic [7:0] b, output logic e, input int d);
    @(posedge i_clk) #2;
    o_atn_n = 1'b1;
    o_ndac_oe_n = 1'b0;
    o_nrfd_oe_n = 1'b1;
    do @(negedge i_clk); while (i_dav_n);
    b = ~i_dio_n;
    e = !i_eoi_n;
    @(posedge i_clk) #2 o_nrfd_oe_n = 1'b0;
    repeat (d + 1) @(posedge i_clk);
    #2 o_ndac_oe_n = 1'b1;
    do @(negedge i_clk); while (!i_dav_n);
    @(posedge i_clk) #2 o_ndac_oe_n = 1'b0;
  endtask : recv
endmodule : gpdi_ctl_model

/* tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("Error at %0t: got %h exp %h", $time, a, b); end end
module tb;
  localparam logic [7:0] PA = 8'h0A;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_srq_req = 1'b0, i_rx_ready = 1'b0;
  logic i_tx_valid = 1'b0, i_tx_last = 1'b0, re;
  logic [7:0] i_tx_data = 8'h00, rb, o_dio_n, o_rx_data, m_dio;
  logic [5:0] i_status = 6'h15;
  logic [4:0] i_pri_addr = 5'h0A;
  logic i_atn_n, i_ifc_n, i_ren_n, m_dio_oe, m_eoi_oe, m_dav_oe, m_nrfd_oe, m_ndac_oe;
  logic o_dio_oe_n, o_eoi_n, o_eoi_oe_n, o_srq_n, o_srq_oe_n, o_dav_n, o_dav_oe_n;
  logic o_nrfd_n, o_nrfd_oe_n, o_ndac_n, o_ndac_oe_n, o_rx_valid, o_rx_last, o_tx_ready;
  logic o_remote, o_lockout, o_talker, o_listener, o_poll_mode, o_dev_clear, o_trigger;
  int n_fail = 0, cmp_count = 0, cyc = 0, n_trig = 0, n_clr = 0;
  // open-drain wiring, pull-ups give the released high level
  wire logic [7:0] i_dio_n = (o_dio_oe_n ? 8'hFF : o_dio_n) & (m_dio_oe ? 8'hFF : m_dio);
  wire logic i_eoi_n = (o_eoi_oe_n | o_eoi_n) & m_eoi_oe;
  wire logic i_dav_n = (o_dav_oe_n | o_dav_n) & m_dav_oe;
  wire logic i_nrfd_n = (o_nrfd_oe_n | o_nrfd_n) & m_nrfd_oe;
  wire logic i_ndac_n = (o_ndac_oe_n | o_ndac_n) & m_ndac_oe;
  wire logic i_srq_n = o_srq_oe_n | o_srq_n;
  gpdi_device DUT (.*);
  gpdi_ctl_model m (.i_clk(i_clk), .i_dio_n(i_dio_n), .i_eoi_n(i_eoi_n), .i_dav_n(i_dav_n),
    .i_ndac_n(i_ndac_n), .i_nrfd_n(i_nrfd_n), .o_dio_n(m_dio), .o_dio_oe_n(m_dio_oe),
    .o_atn_n(i_atn_n), .o_ifc_n(i_ifc_n), .o_ren_n(i_ren_n), .o_eoi_oe_n(m_eoi_oe),
    .o_dav_oe_n(m_dav_oe), .o_nrfd_oe_n(m_nrfd_oe), .o_ndac_oe_n(m_ndac_oe));
  // clock, hang limit and pulse tallies
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc++;
    n_trig += (o_trigger === 1'b1);
    n_clr += (o_dev_clear === 1'b1);
    if (cyc == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task cmd(input logic [7:0] c);
    m.send(c, 1'b1, 1'b0);
    repeat (3) @(posedge i_clk);
    #2;
  endtask : cmd
  task pop(input logic [7:0] d, input logic l);
    `CHK(o_rx_valid, 1'b1)
    `CHK(o_rx_data, d)
    `CHK(o_rx_last, l)
    i_rx_ready = 1'b1;
    @(posedge i_clk) #2 i_rx_ready = 1'b0;
    repeat (2) @(posedge i_clk);
    #2;
  endtask : pop
  task tx_put(input logic [7:0] d, input logic l);
    @(posedge i_clk) #2 i_tx_valid = 1'b1;
    i_tx_data = d;
    i_tx_last = l;
    do @(negedge i_clk); while (o_tx_ready !== 1'b1);
    @(posedge i_clk) #2 i_tx_valid = 1'b0;
  endtask : tx_put
  task t_unaddr;
    `CHK({o_dio_oe_n, o_dav_oe_n, o_eoi_oe_n, o_nrfd_oe_n, o_ndac_oe_n}, 5'h1F)
    m.ctl(1'b1, 1'b0);
    repeat (3) @(posedge i_clk);
    #2 `CHK(o_remote, 1'b1)
    cmd(8'h04);
    cmd(8'h08);
    cmd(8'h01);
    cmd(8'h6A);
    `CHK({o_remote, o_listener, o_talker}, 3'h4)
    `CHK(n_trig + n_clr, 0)
    cmd(8'h14);
    cmd(8'h94);
    `CHK(n_clr, 2)
    cmd(8'h11);
    `CHK(o_lockout, 1'b1)
  endtask : t_unaddr
  // addressed commands, then data into the buffer until it stalls
  task t_listen;
    cmd(PA | 8'h20);
    `CHK(o_listener, 1'b1)
    cmd(8'h08);
    `CHK(n_trig, 1)
    cmd(8'h04);
    `CHK(n_clr, 3)
    cmd(8'h01);
    `CHK({o_remote, o_lockout}, 2'h1)
    m.send(PA | 8'h40, 1'b0, 1'b0);
    m.send(8'h42, 1'b0, 1'b0);
    fork
      m.send(8'h43, 1'b0, 1'b1);
    join_none
    repeat (14) @(posedge i_clk);
    #2 `CHK(o_ndac_oe_n, 1'b0)
    `CHK(o_talker, 1'b0)
    pop(PA | 8'h40, 1'b0);
    pop(8'h42, 1'b0);
    wait fork;
    repeat (3) @(posedge i_clk);
    #2 pop(8'h43, 1'b1);
  endtask : t_listen
  // talking: two bytes, the second to a slow reader, then the poll status byte
  task t_talk;
    // unlisten first: a listening talker would fill its own receive buffer and stall
    cmd(8'h3F);
    `CHK(o_listener, 1'b0)
    cmd(PA | 8'h40);
    `CHK(o_talker, 1'b1)
    fork
      begin
        repeat (2) @(posedge i_clk);
        tx_put(8'h5A, 1'b0);
        tx_put(8'hA3, 1'b1);
      end
      begin
        m.recv(rb, re, 0);
        `CHK({rb, re}, 9'h0B4)
        m.recv(rb, re, 6);
        `CHK({rb, re}, 9'h147)
      end
    join
    i_srq_req = 1'b1;
    #1 `CHK(o_srq_oe_n, 1'b0)
    cmd(8'h18);
    `CHK(o_poll_mode, 1'b1)
    m.recv(rb, re, 0);
    `CHK({rb, re}, {2'h1, i_status, 1'b1})
    cmd(8'h19);
    `CHK(o_poll_mode, 1'b0)
    cmd(8'h5F);
    cmd(8'h3F);
    `CHK({o_talker, o_listener}, 2'h0)
    i_srq_req = 1'b0;
    #1 `CHK(o_srq_oe_n, 1'b1)
  endtask : t_talk
  task t_ifc;
    cmd(PA | 8'h20);
    cmd(PA | 8'h40);
    `CHK({o_talker, o_listener, o_remote}, 3'h7)
    m.ctl(1'b1, 1'b1);
    repeat (3) @(posedge i_clk);
    #2 `CHK({o_talker, o_listener}, 2'h0)
    m.ctl(1'b0, 1'b0);
    repeat (4) @(posedge i_clk);
    #2 `CHK({o_remote, o_lockout}, 2'h0)
  endtask : t_ifc
  initial
  begin
    repeat (5) @(posedge i_clk);
    #2 i_rst_n = 1'b1;
    @(posedge i_clk) #2;
    t_unaddr();
    t_listen();
    t_talk();
    t_ifc();
    end_sim();
  end
endmodule : tb
